// [shared/ppc_map.svh]
/*
 * register map, field positions, reset values and timing counts of the
 * picture processor control port. assumes inclusion by both link ends.
 */
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
// ----------------------------------------------------------------------
// bus address and register offsets
// ----------------------------------------------------------------------
`define PPC_SLAVE_ADDR 7'h15
`define PPC_OFS_MODE 8'h00
`define PPC_OFS_LUMA 8'h01
`define PPC_OFS_LINE 8'h02
`define PPC_OFS_TEST 8'h03
`define PPC_REG_COUNT 8'h04
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PPC_MODE_HI 7
`define PPC_MODE_LO 6
`define PPC_BORDER_BIT 5
`define PPC_UNUSED_BIT 4
`define PPC_SPLIT_BIT 3
`define PPC_RECORDER_BIT 2
`define PPC_FILTER_BIT 1
`define PPC_WIDTH_BIT 0
`define PPC_UPPER_HI 7
`define PPC_UPPER_LO 5
`define PPC_THR_HI 4
`define PPC_CLSF_BIT 7
`define PPC_COEF_BIT 4
// ----------------------------------------------------------------------
// operating mode codes and reset values
// ----------------------------------------------------------------------
`define PPC_MODE_NORMAL 2'h0
`define PPC_MODE_MULTI 2'h1
`define PPC_RST_MODE 8'h00
`define PPC_RST_LUMA 8'h04
`define PPC_RST_LINE 8'h10
`define PPC_RST_TEST 8'h00
// ----------------------------------------------------------------------
// video path figures and timing
// ----------------------------------------------------------------------
`define PPC_PIX_411_BITS 12
`define PPC_PIX_422_BITS 16
`define PPC_PIX_KHZ 13500
`define PPC_LINE_MEM_PIX 208
`define PPC_SYS_HZ 125000000
`define PPC_SCL_HZ 100000
`define PPC_SCL_QTR_CYC (`PPC_SYS_HZ / (4 * `PPC_SCL_HZ))
`define PPC_MSC_GAP_MS 30
`define PPC_MSC_GAP_CYC ((`PPC_SYS_HZ / 1000) * `PPC_MSC_GAP_MS)
`endif

// [shared/ppc_pkg.sv]
/*
 * types shared by both ends of the control link.
 * assumes nothing beyond the map header.
 */
package ppc_pkg;
    // slave receiver states
    typedef enum logic [1:0] {
        SL_IDLE, SL_RECV, SL_ACK, SL_SKIP
    } ppc_slv_state_e;
    // master transmitter states
    typedef enum logic [1:0] {
        MS_IDLE, MS_START, MS_BIT, MS_STOP
    } ppc_mst_state_e;
endpackage : ppc_pkg

// [shared/ppc_link_if.sv]
/*
 * two-wire control link between host and picture processor.
 * assumes pull-ups: a wire is low only while some end enables it.
 */
`timescale 1ns/100ps
interface ppc_link_if;
    logic hostSclOe; // host pulls clock low
    logic hostSdaOe; // host pulls data low
    logic devSdaOe; // device pulls data low (acknowledge)
    logic scl; // resolved clock level
    logic sda; // resolved data level
    // wired-and of open-drain drivers
    assign scl = ~hostSclOe;
    assign sda = ~(hostSdaOe | devSdaOe);
    modport host (output hostSclOe, output hostSdaOe, input scl, input sda);
    modport dev (output devSdaOe, input scl, input sda);
endinterface : ppc_link_if

// [design/ppc_host.sv]
/*
 * host end: write-only two-wire master for the picture processor.
 * assumes user pulses startReq only while busy_r is low.
 */
`timescale 1ns/100ps
`include "ppc_map.svh"
module ppc_host #(
    parameter int QTR_CYC = `PPC_SCL_QTR_CYC,
    parameter int MSC_GAP_CYC = `PPC_MSC_GAP_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    ppc_link_if.host link,
    input wire logic startReq,
    input wire logic [7:0] subAddr,
    input wire logic [31:0] wrData,
    input wire logic [2:0] wrCount,
    input wire logic mscSent,
    output logic busy_r,
    output logic done_r,
    output logic ackFail_r,
    output logic mscDue_r,
    output logic mscLate_r
);
    import ppc_pkg::*;
    // ------------------------------------------------------------------
    // data line input synchroniser
    // ------------------------------------------------------------------
    logic sda1_r, sda2_r, sda3_r, sdaF_r; // three stages plus level
    // change taken once stages two and three agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {sda1_r, sda2_r, sda3_r, sdaF_r} <= 4'hf;
        end else begin
            sda1_r <= link.sda;
            sda2_r <= sda1_r;
            sda3_r <= sda2_r;
            sdaF_r <= (sda2_r == sda3_r) ? sda3_r : sdaF_r;
        end
    end
    // ------------------------------------------------------------------
    // quarter bit divider and frame state
    // ------------------------------------------------------------------
    ppc_mst_state_e state_r;
    logic [15:0] qCnt_r; // quarter period down counter
    logic [1:0] phase_r; // quarter within a bit
    logic [3:0] bitIdx_r; // 0..7 data, 8 acknowledge
    logic [2:0] byteIdx_r; // 0 address, 1 subaddress, then data
    logic [2:0] lastIdx_r; // index of last byte of the frame
    logic [7:0] sub_r; // latched subaddress
    logic [31:0] data_r; // latched data, low byte first
    logic sclOe_r, sdaOe_r;
    logic [22:0] gapCnt_r; // follow-up window counter
    wire tick = (qCnt_r == 16'h0000);
    wire [2:0] cnt = (wrCount > 3'h4) ? 3'h4 : wrCount;
    wire [7:0] dataByte = data_r[8 * (byteIdx_r - 3'h2) +: 8];
    wire [7:0] addrByte = {`PPC_SLAVE_ADDR, 1'b0};
    wire [7:0] curByte = (byteIdx_r == 3'h0) ? addrByte :
                         (byteIdx_r == 3'h1) ? sub_r : dataByte;
    wire bitVal = curByte[3'h7 - bitIdx_r[2:0]];
    wire ackBit = (bitIdx_r == 4'h8);
    wire wroteMode = (sub_r == `PPC_OFS_MODE) && (lastIdx_r > 3'h1);
    assign link.hostSclOe = sclOe_r;
    assign link.hostSdaOe = sdaOe_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= MS_IDLE;
            qCnt_r <= 16'h0000;
            phase_r <= 2'h0;
            bitIdx_r <= 4'h0;
            byteIdx_r <= 3'h0;
            lastIdx_r <= 3'h0;
            sub_r <= 8'h00;
            data_r <= 32'h00000000;
            sclOe_r <= 1'b0;
            sdaOe_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            ackFail_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            qCnt_r <= tick ? 16'(QTR_CYC - 1) : qCnt_r - 16'h0001;
            case (state_r)
                MS_IDLE: begin
                    if (startReq) begin // latch the frame
                        state_r <= MS_START;
                        qCnt_r <= 16'(QTR_CYC - 1);
                        phase_r <= 2'h0;
                        sub_r <= subAddr;
                        data_r <= wrData;
                        lastIdx_r <= cnt + 3'h1;
                        byteIdx_r <= 3'h0;
                        bitIdx_r <= 4'h0;
                        busy_r <= 1'b1;
                        ackFail_r <= 1'b0;
                    end
                end
                MS_START: if (tick) begin // data falls while clock high
                    phase_r <= phase_r + 2'h1;
                    if (phase_r == 2'h1) sdaOe_r <= 1'b1;
                    if (phase_r == 2'h2) sclOe_r <= 1'b1;
                    if (phase_r == 2'h3) state_r <= MS_BIT;
                end
                MS_BIT: if (tick) begin
                    phase_r <= phase_r + 2'h1;
                    case (phase_r)
                        2'h0: sdaOe_r <= ackBit ? 1'b0 : ~bitVal;
                        2'h1: sclOe_r <= 1'b0; // clock rises
                        2'h2: if (ackBit && sdaF_r) ackFail_r <= 1'b1;
                        default: begin // clock falls, advance
                            sclOe_r <= 1'b1;
                            if (!ackBit) begin
                                bitIdx_r <= bitIdx_r + 4'h1;
                            end else if (ackFail_r ||
                                         byteIdx_r == lastIdx_r) begin
                                state_r <= MS_STOP;
                            end else begin
                                bitIdx_r <= 4'h0;
                                byteIdx_r <= byteIdx_r + 3'h1;
                            end
                        end
                    endcase
                end
                MS_STOP: if (tick) begin // data rises while clock high
                    phase_r <= phase_r + 2'h1;
                    if (phase_r == 2'h0) sdaOe_r <= 1'b1;
                    if (phase_r == 2'h1) sclOe_r <= 1'b0;
                    if (phase_r == 2'h2) sdaOe_r <= 1'b0;
                    if (phase_r == 2'h3) begin
                        state_r <= MS_IDLE;
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                    end
                end
                default: state_r <= MS_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------------
    // follow-up window for the sync controller
    // ------------------------------------------------------------------
    // mode to sync controller within window
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mscDue_r <= 1'b0;
            mscLate_r <= 1'b0;
            gapCnt_r <= 23'h000000;
        end else begin
            mscLate_r <= 1'b0;
            if (done_r && !ackFail_r && wroteMode) begin
                mscDue_r <= 1'b1;
                gapCnt_r <= 23'(MSC_GAP_CYC - 1);
            end else if (mscDue_r && mscSent) begin
                mscDue_r <= 1'b0;
            end else if (mscDue_r) begin
                gapCnt_r <= gapCnt_r - 23'h000001;
                if (gapCnt_r == 23'h000000) begin
                    mscDue_r <= 1'b0;
                    mscLate_r <= 1'b1;
                end
            end
        end
    end
endmodule : ppc_host

// [design/ppc_device.sv]
/*
 * device end: write-only two-wire slave and mode registers of the
 * picture processor. assumes rst_n is the internal power-on reset and
 * the pixel path that consumes these controls lives elsewhere.
 */
`timescale 1ns/100ps
`include "ppc_map.svh"
module ppc_device #(
    parameter int LINE_MEM_PIX = `PPC_LINE_MEM_PIX,
    parameter int PIX_411_BITS = `PPC_PIX_411_BITS,
    parameter int PIX_422_BITS = `PPC_PIX_422_BITS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    ppc_link_if.dev link,
    input wire logic vertical_blank_pulse,
    input wire logic transfer_request,
    input wire logic input_format_pin,
    input wire logic output_format_pin,
    input wire logic rightHalf,
    input wire logic noiseValid,
    input wire logic [4:0] noiseLevel,
    output logic [7:0] modeCtrl_r,
    output logic [7:0] lumaLow_r,
    output logic [7:0] lineHigh_r,
    output logic [7:0] testOvr_r,
    output logic [1:0] activeMode_r,
    output logic [2:0] measureLine_r,
    output logic [1:0] noiseClass_r,
    output logic [3:0] filterCoef_r,
    output logic filterBypass_r,
    output logic decimateEn_r,
    output logic interpolateEn_r
);
    import ppc_pkg::*;
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // measurement line decode
    function automatic logic [2:0] line_decode(input logic [2:0] code);
        case (code)
            3'h1: line_decode = 3'h0;
            3'h2: line_decode = 3'h1;
            3'h3: line_decode = 3'h2;
            3'h4: line_decode = 3'h3;
            3'h5: line_decode = 3'h5;
            3'h6: line_decode = 3'h7;
            default: line_decode = 3'h4;
        endcase
    endfunction : line_decode
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // bit 0 clock, 1 data, 2 blanking, 3 request, 4 in fmt, 5 out fmt
    logic [5:0] s1_r, s2_r, s3_r, lvl_r; // three stages plus level
    wire [5:0] pinRaw = {output_format_pin, input_format_pin,
                         transfer_request, vertical_blank_pulse,
                         link.sda, link.scl};
    wire [5:0] agree = ~(s2_r ^ s3_r);
    wire [5:0] lvlNxt = (agree & s3_r) | (~agree & lvl_r);
    // level updates only when the last two stages agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 6'h03;
            s2_r <= 6'h03;
            s3_r <= 6'h03;
            lvl_r <= 6'h03;
        end else begin
            s1_r <= pinRaw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvlNxt;
        end
    end
    // ------------------------------------------------------------------
    // bus condition detection
    // ------------------------------------------------------------------
    wire sclRise = lvlNxt[0] & ~lvl_r[0];
    wire sclFall = ~lvlNxt[0] & lvl_r[0];
    wire sclHigh = lvlNxt[0] & lvl_r[0];
    wire startDet = sclHigh & lvl_r[1] & ~lvlNxt[1];
    wire stopDet = sclHigh & ~lvl_r[1] & lvlNxt[1];
    wire blankReq = lvl_r[2] & lvl_r[3];
    // ------------------------------------------------------------------
    // slave receiver
    // ------------------------------------------------------------------
    ppc_slv_state_e state_r;
    logic [7:0] shift_r; // incoming byte, msb first
    logic [3:0] bitCnt_r; // bits taken of current byte
    logic [1:0] byteIdx_r; // 0 address, 1 subaddress, 2 data
    logic [7:0] sub_r; // current register pointer
    logic sdaOe_r; // acknowledge drive
    wire byteDone = (state_r == SL_RECV) && sclFall && (bitCnt_r == 4'h8);
    wire addrHit = (shift_r == {`PPC_SLAVE_ADDR, 1'b0});
    wire wrEn = byteDone && (byteIdx_r == 2'h2);
    wire regHit = (sub_r < `PPC_REG_COUNT);
    assign link.devSdaOe = sdaOe_r;
    // receive only, never drives data bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= SL_IDLE;
            shift_r <= 8'h00;
            bitCnt_r <= 4'h0;
            byteIdx_r <= 2'h0;
            sub_r <= 8'h00;
            sdaOe_r <= 1'b0;
        end else if (startDet) begin // start or repeated start
            state_r <= SL_RECV;
            bitCnt_r <= 4'h0;
            byteIdx_r <= 2'h0;
            sdaOe_r <= 1'b0;
        end else if (stopDet) begin
            state_r <= SL_IDLE;
            sdaOe_r <= 1'b0;
        end else begin
            case (state_r)
                SL_RECV: begin
                    if (sclRise && bitCnt_r != 4'h8) begin
                        shift_r <= {shift_r[6:0], lvlNxt[1]};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end
                    if (byteDone) begin
                        if (byteIdx_r == 2'h0 && !addrHit) begin
                            state_r <= SL_SKIP;
                        end else begin
                            state_r <= SL_ACK;
                            sdaOe_r <= 1'b1;
                        end
                        if (byteIdx_r == 2'h1) sub_r <= shift_r;
                        // pointer steps after each data byte
                        if (byteIdx_r == 2'h2) sub_r <= sub_r + 8'h01;
                    end
                end
                SL_ACK: if (sclFall) begin // release after ninth clock
                    sdaOe_r <= 1'b0;
                    state_r <= SL_RECV;
                    bitCnt_r <= 4'h0;
                    if (byteIdx_r != 2'h2) byteIdx_r <= byteIdx_r + 2'h1;
                end
                SL_SKIP: sdaOe_r <= 1'b0; // wait for next start
                default: state_r <= SL_IDLE; // idle waits for start
            endcase
        end
    end
    // ------------------------------------------------------------------
    // register file and mode switching
    // ------------------------------------------------------------------
    logic [1:0] pendMode_r; // mode waiting for blanking
    logic pendValid_r;
    wire [1:0] newMode = shift_r[`PPC_MODE_HI:`PPC_MODE_LO];
    wire modeWr = wrEn && regHit && (sub_r == `PPC_OFS_MODE);
    wire multiOp = (activeMode_r == `PPC_MODE_MULTI) ||
                   (newMode == `PPC_MODE_MULTI);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modeCtrl_r <= `PPC_RST_MODE;
            lumaLow_r <= `PPC_RST_LUMA;
            lineHigh_r <= `PPC_RST_LINE;
            testOvr_r <= `PPC_RST_TEST;
        end else if (wrEn && regHit) begin
            case (sub_r)
                // mode and control bits, dead bit zero
                `PPC_OFS_MODE: begin
                    modeCtrl_r <= shift_r;
                    modeCtrl_r[`PPC_UNUSED_BIT] <= 1'b0;
                end
                `PPC_OFS_LUMA: lumaLow_r <= shift_r;
                `PPC_OFS_LINE: lineHigh_r <= shift_r;
                default: testOvr_r <= shift_r;
            endcase
        end
    end
    // defer multi-picture mode to blanking request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            activeMode_r <= `PPC_MODE_NORMAL;
            pendMode_r <= `PPC_MODE_NORMAL;
            pendValid_r <= 1'b0;
        end else if (modeWr && multiOp) begin // newest write wins
            pendMode_r <= newMode;
            pendValid_r <= 1'b1;
        end else if (modeWr) begin
            activeMode_r <= newMode;
            pendValid_r <= 1'b0;
        end else if (pendValid_r && blankReq) begin
            activeMode_r <= pendMode_r;
            pendValid_r <= 1'b0;
        end
    end
    // ------------------------------------------------------------------
    // derived video controls
    // ------------------------------------------------------------------
    wire [4:0] lowThr = lumaLow_r[`PPC_THR_HI:0];
    wire [4:0] highThr = lineHigh_r[`PPC_THR_HI:0];
    // class boundaries from the two thresholds
    wire [1:0] autoClass = (noiseLevel < lowThr) ? 2'h0 :
                           (noiseLevel > highThr) ? 2'h2 : 2'h1;
    wire [1:0] forcedClass = (testOvr_r[6:5] == 2'h3) ? 2'h2 :
                             testOvr_r[6:5];
    wire recorder = modeCtrl_r[`PPC_RECORDER_BIT];
    wire splitOn = modeCtrl_r[`PPC_SPLIT_BIT];
    wire filterOn = modeCtrl_r[`PPC_FILTER_BIT];
    // video controls registered straight to outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            measureLine_r <= 3'h4;
            noiseClass_r <= 2'h1;
            filterCoef_r <= 4'h0;
            filterBypass_r <= 1'b1;
            decimateEn_r <= 1'b0;
            interpolateEn_r <= 1'b0;
        end else begin
            measureLine_r <= line_decode(lineHigh_r[7:5]);
            if (testOvr_r[`PPC_CLSF_BIT]) begin
                noiseClass_r <= forcedClass;
            end else if (noiseValid && !recorder) begin
                noiseClass_r <= autoClass;
            end
            // coefficient from class or forced code
            filterCoef_r <= testOvr_r[`PPC_COEF_BIT] ? testOvr_r[3:0] :
                            {2'h0, noiseClass_r};
            // split screen leaves right half unfiltered
            filterBypass_r <= !filterOn || (splitOn && rightHalf);
            decimateEn_r <= lvl_r[4];
            interpolateEn_r <= lvl_r[5];
        end
    end
    // pixel bus and line memory sizes held as parameters
endmodule : ppc_device

// [bench/ppc_link_asserts.sv]
/* wire checks on the two-wire control link.
   assumes it sits beside the interface that joins host and device. */
`timescale 1ns/100ps
module ppc_link_asserts (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hostSclOe,
    input wire logic hostSdaOe,
    input wire logic devSdaOe,
    input wire logic scl,
    input wire logic sda
);
    // all checks live in the system clock domain
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_ack_rise_low: assert property ($rose(devSdaOe) |-> !scl)
        else $error("ack raised while clock high");
    a_ack_fall_low: assert property ($fell(devSdaOe) |-> !scl)
        else $error("ack dropped while clock high");
    a_ack_steady_high: assert property ((scl && $past(scl)) |->
        $stable(devSdaOe)) else $error("data moved by device, clock high");
    a_ack_min_len: assert property ($rose(devSdaOe) |->
        devSdaOe[*8]) else $error("ack too short");
    a_ack_max_len: assert property ($rose(devSdaOe) |->
        ##[20:40] !devSdaOe) else $error("ack held too long");
    a_ack_clocked: assert property ($rose(devSdaOe) |->
        ##[1:20] scl) else $error("ack without a clock pulse");
    a_start_by_host: assert property (($fell(sda) && scl) |->
        hostSdaOe) else $error("start made by device");
    a_dev_data_quiet: assert property ((scl && hostSdaOe) |-> !devSdaOe)
        else $error("device drove data while host drove the line");
    // main link events
    c_ack: cover property ($rose(devSdaOe));
    c_start: cover property ($fell(sda) && scl);
    c_stop: cover property ($rose(sda) && scl);
endmodule : ppc_link_asserts

// [bench/picture_processor_i2c_control_bench.sv]
/* bench: host end writes the device end over the link, registers checked.
   assumes map header, package and interface are compiled first. */
`timescale 1ns/100ps
`include "ppc_map.svh"
module picture_processor_i2c_control_bench;
    `define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
        error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
    logic clk_sys = 0, rst_n = 0, startReq = 0, mscSent = 0;
    logic [7:0] subAddr = 0;
    logic [31:0] wrData = 0;
    logic [2:0] wrCount = 0;
    logic vertical_blank_pulse = 0, transfer_request = 0, rightHalf = 0;
    logic input_format_pin = 0, output_format_pin = 0, noiseValid = 0;
    logic [4:0] noiseLevel = 0;
    logic busy_r, done_r, ackFail_r, mscDue_r, mscLate_r;
    logic [7:0] modeCtrl_r, lumaLow_r, lineHigh_r, testOvr_r;
    logic [1:0] activeMode_r, noiseClass_r;
    logic [2:0] measureLine_r;
    logic [3:0] filterCoef_r;
    logic filterBypass_r, decimateEn_r, interpolateEn_r;
    logic [7:0] expR [4] = '{8'h00, 8'h04, 8'h10, 8'h00}; // reset image
    int error_cnt = 0, samples_checked = 0;
    ppc_link_if lnk();
    // small counts keep telegrams short
    localparam int GAP = 50; // follow-up window in cycles
    ppc_host #(.QTR_CYC(8), .MSC_GAP_CYC(GAP)) ppc_host_inst (.clk_sys,
        .rst_n, .link(lnk), .startReq, .subAddr, .wrData, .wrCount,
        .mscSent, .busy_r, .done_r, .ackFail_r, .mscDue_r, .mscLate_r);
    ppc_device ppc_device_inst (.clk_sys, .rst_n, .link(lnk),
        .vertical_blank_pulse, .transfer_request, .input_format_pin,
        .output_format_pin, .rightHalf, .noiseValid, .noiseLevel,
        .modeCtrl_r, .lumaLow_r, .lineHigh_r, .testOvr_r, .activeMode_r,
        .measureLine_r, .noiseClass_r, .filterCoef_r, .filterBypass_r,
        .decimateEn_r, .interpolateEn_r);
    ppc_link_asserts ppc_link_asserts_inst (.clk_sys, .rst_n,
        .hostSclOe(lnk.hostSclOe), .hostSdaOe(lnk.hostSdaOe),
        .devSdaOe(lnk.devSdaOe), .scl(lnk.scl), .sda(lnk.sda));
    // 125 MHz system clock
    initial forever #4 clk_sys = ~clk_sys;
    // watchdog: some fourteen telegrams need well under 40k cycles
    initial begin
        #500000;
        error_cnt++;
        end_of_test();
    end
    // expected measurement line for a code
    function automatic logic [2:0] line_of(input logic [2:0] c);
        case (c)
            3'h0, 3'h7: return 3'h4;
            3'h5: return 3'h5;
            3'h6: return 3'h7;
            default: return c - 3'h1;
        endcase
    endfunction : line_of
    // one telegram, then update the expected image
    task automatic send(input logic [7:0] sa, input logic [31:0] d,
        input logic [2:0] n);
        int k;
        @(negedge clk_sys);
        subAddr = sa;
        wrData = d;
        wrCount = n;
        startReq = 1;
        @(negedge clk_sys);
        startReq = 0;
        `CHK("busy", 1'b1, busy_r)
        for (k = 0; k < 4000 && done_r !== 1'b1; k++) @(negedge clk_sys);
        `CHK("done", 1'b1, done_r)
        @(negedge clk_sys);
        for (k = 0; k < n; k++) if (sa + k < 4) expR[sa + k] = d[8*k +: 8];
        expR[0][4] = 1'b0;
        `CHK("ackFail", 1'b0, ackFail_r)
        `CHK("mscDue", (sa == 0 && n != 0), mscDue_r)
    endtask : send
    // compare every register and the derived mode, line, bypass and format outputs
    task automatic check_regs();
        logic b;
        repeat (6) @(negedge clk_sys);
        b = !expR[0][1] | (expR[0][3] & rightHalf);
        `CHK("mode", expR[0], modeCtrl_r)
        `CHK("luma", expR[1], lumaLow_r)
        `CHK("line", expR[2], lineHigh_r)
        `CHK("test", expR[3], testOvr_r)
        `CHK("amode", expR[0][7:6], activeMode_r)
        `CHK("mline", line_of(expR[2][7:5]), measureLine_r)
        `CHK("bypass", b, filterBypass_r)
        `CHK("decim", input_format_pin, decimateEn_r)
        `CHK("interp", output_format_pin, interpolateEn_r)
    endtask : check_regs
    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    // main sequence
    initial begin
        logic [7:0] s;
        logic [31:0] d;
        logic [1:0] m;
        int k;
        int lvl [3];
        void'($urandom(32'h805c));
        lvl = '{3, 10, 25};
        repeat (6) @(negedge clk_sys);
        rst_n = 1;
        repeat (8) @(negedge clk_sys);
        check_regs();
        $display("test reset done");
        send(8'h01, 32'h0000_1405, 3'h3);
        for (k = 0; k < 3; k++) begin
            noiseLevel = 5'(lvl[k]);
            noiseValid = 1;
            @(negedge clk_sys);
            noiseValid = 0;
            repeat (3) @(negedge clk_sys);
            `CHK("class", 2'(k), noiseClass_r)
            `CHK("coef", {2'h0, 2'(k)}, filterCoef_r)
        end
        // host sets the recorder bit, class must freeze
        send(8'h00, 32'h0000_0004, 3'h1);
        repeat (GAP) @(negedge clk_sys);
        `CHK("late", 1'b1, mscLate_r)
        noiseLevel = 5'h03;
        noiseValid = 1;
        @(negedge clk_sys);
        noiseValid = 0;
        repeat (3) @(negedge clk_sys);
        `CHK("frozen", 2'h2, noiseClass_r)
        $display("test classes done");
        for (k = 0; k < 10; k++) begin
            s = (k == 0) ? 8'h0 : 8'($urandom_range(3));
            d = $urandom;
            if (d[7:6] == 2'h1) d[7] = 1'b1;
            {rightHalf, input_format_pin, output_format_pin} = 3'($urandom);
            send(s, d, (k == 0) ? 3'h4 : 3'($urandom_range(4 - s, 1)));
            check_regs();
        end
        send(8'h04, $urandom, 3'h1);
        check_regs();
        $display("test writes done");
        m = expR[0][7:6];
        send(8'h00, 32'h0000_0040, 3'h1);
        mscSent = 1;
        @(negedge clk_sys);
        mscSent = 0;
        `CHK("mscDue", 1'b0, mscDue_r)
        vertical_blank_pulse = 1;
        repeat (10) @(negedge clk_sys);
        `CHK("pend", m, activeMode_r)
        transfer_request = 1;
        repeat (10) @(negedge clk_sys);
        `CHK("apply", 2'h1, activeMode_r)
        $display("test multi done");
        end_of_test();
    end
endmodule : picture_processor_i2c_control_bench
